// *** design/mic_map.vh ***
// Purpose: constants for the mac interface control register bank
// Assumes: apb with 32-bit data, one word per register
// Notes:   register index 0x0017 gives byte address 0x5c
`ifndef MIC_MAP_VH
`define MIC_MAP_VH

// register indices and byte addresses
`define MIC_CTRL_IDX        16'h0017
`define MIC_CTRL_ADDR       12'h05C
`define MIC_IRQ_STAT_ADDR   12'h060
`define MIC_IRQ_MASK_ADDR   12'h064

// field positions
`define MIC_SGMII_THR_HI    14
`define MIC_SGMII_THR_LO    13
`define MIC_RX_DLY_BIT      12
`define MIC_TX_DLY_BIT      11
`define MIC_RSVD10_BIT      10
`define MIC_RGMII_BIT       9
`define MIC_RSVD8_BIT       8
`define MIC_CLK_SEL_BIT     7
`define MIC_RSVD6_BIT       6
`define MIC_RMII_BIT        5
`define MIC_REV_BIT         4
`define MIC_OVF_BIT         3
`define MIC_UNF_BIT         2
`define MIC_EBUF_HI         1
`define MIC_EBUF_LO         0

// reset values
`define MIC_SGMII_THR_RST   2'b10
`define MIC_EBUF_RST        2'b01
`define MIC_RSVD6_RST       1'b1
`define MIC_REV_RST         1'b0

// interface mode encodings
`define MIC_MODE_MII        2'b00
`define MIC_MODE_RMII       2'b01
`define MIC_MODE_RGMII      2'b10

// timing: rgmii rx clock delay in ps, clock period in ps
`define MIC_RX_DLY_PS       2000
`define MIC_CLK_PERIOD_PS   10000
`define MIC_RX_DLY_CYC      2'd1

// interrupt status bits
`define MIC_IRQ_OVF_BIT     0
`define MIC_IRQ_UNF_BIT     1

`endif

// *** design/mic_regs.v ***
// Purpose: mac interface control register with apb slave and interrupt
// Assumes: straps stable around reset release, fifo events one-cycle pulses
// Notes:   mode, delay and threshold controls are flop outputs
// Notes on behaviour
// - sgmii half-full threshold code, resets to 10
// - rx delay bit delays rx clock 2ns
// - rgmii bit forces rgmii, else rmii bit
// - rmii bit picks rmii or mii
// - clock select strap: 50 or 25 MHz
// - revision 1.0: crs_dv held to end
// - revision 1.2: crs_dv toggles at end
// - overflow reads 0 when seen, read clears
// - underflow reads 0 when seen, read clears
// - elasticity buffer code sets tolerance bits
// - control register at index 0x0017
//
// Register access over APB and the register offsets were left to the implementer.
`include "mic_map.vh"

// overview of the bank
// one 16-bit control word, low half of a 32-bit apb word
// upper half of every register reads zero
// two helper registers: event status and event mask
// unmapped offsets answer with pslverr and read zero
//
// strap handling
// strap fields load on the first edge after reset release
// software writes override strap values afterwards
// straps are not looked at again until the next reset
// a strap that moves after release is simply ignored
//
// fifo status bits
// flags are stored active high, shown inverted in the word
// a read of the control word clears both flags
// an event in the clearing cycle keeps its flag set
// yet an event landing at the setup edge, between capture and clear, is lost
//
// timing of derived controls
// every control output is one flop behind its field
// a write lands at the access edge, outputs one edge later
// interrupt output lags the status register by one edge
//
// limits
// rx delay is reported in whole clock cycles, minimum one
// sgmii threshold is passed on as its raw two-bit code
// reserved read-write bits store and read back only

module mic_regs (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        strap_rx_dly,
    input  wire        strap_tx_dly,
    input  wire        strap_rgmii,
    input  wire        strap_clk_sel,
    input  wire        strap_rmii,
    input  wire        rx_fifo_ovf,
    input  wire        rx_fifo_unf,
    output reg  [1:0]  if_mode,
    output reg         rx_clk_dly_en,
    output reg         tx_clk_dly_en,
    output reg         ref_clk_50m,
    output reg         crs_dv_toggle_en,
    output reg  [1:0]  sgmii_thr_bits,
    output reg  [2:0]  ebuf_tol_bits,
    output reg  [1:0]  rx_dly_cycles,
    output reg         irq
);

    reg  [1:0]  sgmii_thr_q;
    reg         rx_dly_q;
    reg         tx_dly_q;
    reg         rsvd10_q;
    reg         rgmii_q;
    reg         rsvd8_q;
    reg         clk_sel_q;
    reg         rsvd6_q;
    reg         rmii_q;
    reg         rev_q;
    reg         ovf_q;
    reg         unf_q;
    reg  [1:0]  ebuf_q;
    reg         strap_done_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    wire        access;
    wire        wr;
    wire        rd;
    wire        hit_ctrl;
    wire        hit_stat;
    wire        hit_mask;
    wire [15:0] ctrl_val;
    reg  [31:0] rdata_d;

    // map elasticity buffer code to tolerance bits
    function [2:0] ebuf_tol;
        input [1:0] code;
        begin
            case (code)
                2'b00:   ebuf_tol = 3'd5;
                2'b01:   ebuf_tol = 3'd2;
                2'b10:   ebuf_tol = 3'd3;
                default: ebuf_tol = 3'd4;
            endcase
        end
    endfunction

    // map sgmii threshold code to bit count index
    function [1:0] thr_code;
        input [1:0] code;
        begin
            thr_code = code;
        end
    endfunction

    // apb decode, one-cycle access
    // decode is purely combinational on the request
    // actions happen only in the access cycle
    assign access   = psel & penable;
    assign wr       = access & pwrite;
    assign rd       = access & ~pwrite;
    assign hit_ctrl = (paddr == `MIC_CTRL_ADDR);
    assign hit_stat = (paddr == `MIC_IRQ_STAT_ADDR);
    assign hit_mask = (paddr == `MIC_IRQ_MASK_ADDR);

    // assembled control word, status bits active low
    // bit 15 is read-only zero, writes to it are dropped
    // bits 3:2 are read-only, fed from the sticky flags
    assign ctrl_val = {1'b0, sgmii_thr_q, rx_dly_q, tx_dly_q, rsvd10_q, rgmii_q, rsvd8_q,
                       clk_sel_q, rsvd6_q, rmii_q, rev_q, ~ovf_q, ~unf_q, ebuf_q};

    // read data mux
    // default zero covers unmapped offsets
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d = {16'h0000, ctrl_val};
        end else if (hit_stat) begin
            rdata_d = {30'h0000_0000, irq_stat_q};
        end else if (hit_mask) begin
            rdata_d = {30'h0000_0000, irq_mask_q};
        end
    end

    // control fields, straps caught once after reset release
    // strap fields are zero during reset itself
    // a write in the strap cycle would be lost, so the
    // master must wait past the first edge after release
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sgmii_thr_q  <= `MIC_SGMII_THR_RST;
            rx_dly_q     <= 1'b0;
            tx_dly_q     <= 1'b0;
            rsvd10_q     <= 1'b0;
            rgmii_q      <= 1'b0;
            rsvd8_q      <= 1'b0;
            clk_sel_q    <= 1'b0;
            rsvd6_q      <= `MIC_RSVD6_RST;
            rmii_q       <= 1'b0;
            rev_q        <= `MIC_REV_RST;
            ebuf_q       <= `MIC_EBUF_RST;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            rx_dly_q     <= strap_rx_dly;
            tx_dly_q     <= strap_tx_dly;
            rgmii_q      <= strap_rgmii;
            clk_sel_q    <= strap_clk_sel;
            rmii_q       <= strap_rmii;
        end else if (wr && hit_ctrl) begin
            sgmii_thr_q  <= pwdata[`MIC_SGMII_THR_HI:`MIC_SGMII_THR_LO];
            rx_dly_q     <= pwdata[`MIC_RX_DLY_BIT];
            tx_dly_q     <= pwdata[`MIC_TX_DLY_BIT];
            rsvd10_q     <= pwdata[`MIC_RSVD10_BIT];
            rgmii_q      <= pwdata[`MIC_RGMII_BIT];
            rsvd8_q      <= pwdata[`MIC_RSVD8_BIT];
            clk_sel_q    <= pwdata[`MIC_CLK_SEL_BIT];
            rsvd6_q      <= pwdata[`MIC_RSVD6_BIT];
            rmii_q       <= pwdata[`MIC_RMII_BIT];
            rev_q        <= pwdata[`MIC_REV_BIT];
            ebuf_q       <= pwdata[`MIC_EBUF_HI:`MIC_EBUF_LO];
        end
    end

    // fifo error flags, set wins over clear on read
    // clear acts at the access edge of a control word read
    // the read data was captured one edge earlier
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            if (rx_fifo_ovf) begin
                ovf_q <= 1'b1;
            end else if (rd && hit_ctrl) begin
                ovf_q <= 1'b0;
            end
            if (rx_fifo_unf) begin
                unf_q <= 1'b1;
            end else if (rd && hit_ctrl) begin
                unf_q <= 1'b0;
            end
        end
    end

    // interrupt status, write one to clear, mask register
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
        end else begin
            // overflow status bit: event sets, write one clears
            if (rx_fifo_ovf) begin
                irq_stat_q[`MIC_IRQ_OVF_BIT] <= 1'b1;
            end else if (wr && hit_stat && pwdata[`MIC_IRQ_OVF_BIT]) begin
                irq_stat_q[`MIC_IRQ_OVF_BIT] <= 1'b0;
            end
            // underflow status bit: event sets, write one clears
            if (rx_fifo_unf) begin
                irq_stat_q[`MIC_IRQ_UNF_BIT] <= 1'b1;
            end else if (wr && hit_stat && pwdata[`MIC_IRQ_UNF_BIT]) begin
                irq_stat_q[`MIC_IRQ_UNF_BIT] <= 1'b0;
            end
            // mask register, plain read-write
            if (wr && hit_mask) begin
                irq_mask_q <= pwdata[1:0];
            end
        end
    end

    // apb answer, zero wait states
    // ready rises on the setup edge, stands in the access cycle
    // read data is registered with it and zero otherwise
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~(hit_ctrl | hit_stat | hit_mask);
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // derived controls toward the mac datapath
    // reset levels match the field reset values
    // strap-fed outputs follow one edge after the strap load
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            if_mode          <= `MIC_MODE_MII;
            rx_clk_dly_en    <= 1'b0;
            tx_clk_dly_en    <= 1'b0;
            ref_clk_50m      <= 1'b0;
            crs_dv_toggle_en <= 1'b1;
            sgmii_thr_bits   <= `MIC_SGMII_THR_RST;
            ebuf_tol_bits    <= 3'd2;
            rx_dly_cycles    <= 2'd0;
            irq              <= 1'b0;
        end else begin
            if (rgmii_q) begin
                if_mode <= `MIC_MODE_RGMII;
            end else if (rmii_q) begin
                if_mode <= `MIC_MODE_RMII;
            end else begin
                if_mode <= `MIC_MODE_MII;
            end
            rx_clk_dly_en    <= rx_dly_q;
            rx_dly_cycles    <= rx_dly_q ? `MIC_RX_DLY_CYC : 2'd0;
            tx_clk_dly_en    <= tx_dly_q;
            ref_clk_50m      <= clk_sel_q;
            crs_dv_toggle_en <= ~rev_q;
            sgmii_thr_bits   <= thr_code(sgmii_thr_q);
            ebuf_tol_bits    <= ebuf_tol(ebuf_q);
            irq              <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule

// *** test/mic_checker.sv ***
// Purpose: port checks for the mac interface control bank
// Assumes: single clock, async active-low reset
// Notes: derived outputs settle one edge after the write edge
`include "mic_map.vh"
module mic_checker (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [1:0]  if_mode,
    input wire logic        rx_clk_dly_en,
    input wire logic        tx_clk_dly_en,
    input wire logic        ref_clk_50m,
    input wire logic        crs_dv_toggle_en,
    input wire logic [1:0]  sgmii_thr_bits,
    input wire logic [2:0]  ebuf_tol_bits,
    input wire logic [1:0]  rx_dly_cycles,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // accepted control word write
    wire wr = psel && penable && pready && pwrite && paddr == `MIC_CTRL_ADDR;
    a_thr_copy: assert property (wr |-> ##2 sgmii_thr_bits == $past(pwdata[14:13], 2))
        else $error("threshold wrong");
    a_rx_delay: assert property (wr |-> ##2 {rx_clk_dly_en, rx_dly_cycles} ==
        {$past(pwdata[12], 2), 1'b0, $past(pwdata[12], 2)}) else $error("rx delay wrong");
    a_mode_rgmii: assert property (wr && pwdata[9] |-> ##2 if_mode == `MIC_MODE_RGMII)
        else $error("rgmii mode wrong");
    a_mode_rmii: assert property (wr && !pwdata[9] |-> ##2 if_mode[1] == 1'b0
        && if_mode[0] == $past(pwdata[5], 2)) else $error("rmii or mii wrong");
    a_clk_sel: assert property (wr |-> ##2 ref_clk_50m == $past(pwdata[7], 2))
        else $error("clock select wrong");
    a_rev_hold: assert property (wr && pwdata[4] |-> ##2 !crs_dv_toggle_en)
        else $error("rev 1.0 wrong");
    a_rev_toggle: assert property (wr && !pwdata[4] |-> ##1 ##1 crs_dv_toggle_en)
        else $error("rev 1.2 wrong");
    a_ebuf_tol: assert property (wr |-> ##2 ebuf_tol_bits == ($past(pwdata[1:0], 2) == 2'b00 ?
        3'h5 : {1'b0, $past(pwdata[1:0], 2)} + 3'h1)) else $error("ebuf wrong");
    a_tx_delay: assert property (wr |-> ##2 tx_clk_dly_en == $past(pwdata[11], 2))
        else $error("tx delay wrong");
    // main scenarios reached
    c_write: cover property (wr);
    c_read: cover property (psel && penable && pready && !pwrite);
    c_irq: cover property ($rose(irq));
endmodule
bind mic_regs mic_checker i_mic_checker (.*);

// *** test/mic_mac_model.sv ***
// Purpose: mac side stand-in driving straps and rx fifo events
// Assumes: each request lasts one clock
// Notes: straps are board levels and never move
module mic_mac_model (
    input wire logic clk_sys,
    input wire logic ovf_req,
    input wire logic unf_req,
    output logic     strap_rx_dly,
    output logic     strap_tx_dly,
    output logic     strap_rgmii,
    output logic     strap_clk_sel,
    output logic     strap_rmii,
    output logic     rx_fifo_ovf = 1'b0,
    output logic     rx_fifo_unf = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // board straps: rx delay on, rmii mode
    assign {strap_rx_dly, strap_tx_dly, strap_rgmii, strap_rmii} = 4'h9;
    assign strap_clk_sel = 1'b1;
    // one-cycle fifo event pulses
    always @(posedge clk_sys) begin
        rx_fifo_ovf <= ovf_req;
        rx_fifo_unf <= unf_req;
    end
endmodule

// *** test/testbench.sv ***
// Purpose: self-checking bench for the mac interface control bank
// Assumes: zero-wait apb slave, straps fixed by the mac model
// Notes: control outputs are compared after a full read following each control write
`include "mic_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, irq, err, ovf_req = 0, unf_req = 0;
    logic        strap_rx_dly, strap_tx_dly, strap_rgmii, strap_clk_sel, strap_rmii;
    logic        rx_fifo_ovf, rx_fifo_unf, rx_clk_dly_en, tx_clk_dly_en, ref_clk_50m;
    logic        crs_dv_toggle_en;
    logic [1:0]  if_mode, sgmii_thr_bits, rx_dly_cycles, c;
    logic [2:0]  ebuf_tol_bits;
    logic [15:0] w;
    int          err_count = 0, compares = 0, cyc = 0;
    mic_regs i_mic_regs (.*);
    mic_mac_model i_mic_mac_model (.*);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // cut a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic end_sim();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1;
        repeat (2) @(posedge clk_sys);
        apb(0, `MIC_CTRL_ADDR, 0);
        chk("ctrl reset", rd, 32'h0000_50ED);
        chk("ebuf reset", 32'(ebuf_tol_bits), 32'h0000_0002);
        // every two-bit code, mode and delay; bits 15 and 3:2 ignore writes
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            w = {1'b1, c, c[0], c[1], 1'b0, c[1], 1'b0, c[0], 1'b1, c[0], c[0], 2'b00, c};
            apb(1, `MIC_CTRL_ADDR, {16'h0000, w});
            apb(0, `MIC_CTRL_ADDR, 0);
            chk("readback", rd, {16'h0000, w & 16'h7FF3 | 16'h000C});
            chk("thr", 32'(sgmii_thr_bits), 32'(c));
            chk("mode", 32'(if_mode), c[1] ? 32'h0000_0002 : 32'(c[0]));
            chk("delays", 32'({rx_clk_dly_en, rx_dly_cycles, tx_clk_dly_en}),
                32'({c[0], 1'b0, c[0], c[1]}));
            chk("sel rev", 32'({ref_clk_50m, crs_dv_toggle_en}), 32'({c[0], ~c[0]}));
            chk("ebuf", 32'(ebuf_tol_bits), c == 0 ? 32'h0000_0005 : 32'(c) + 1);
        end
        // fifo events read low once, then normal after the clearing read
        for (int e = 0; e < 2; e++) begin
            ovf_req <= (e == 0);
            unf_req <= (e == 1);
            @(posedge clk_sys);
            ovf_req <= 0;
            unf_req <= 0;
            repeat (2) @(posedge clk_sys);
            apb(0, `MIC_CTRL_ADDR, 0);
            chk("fifo flag", 32'(rd[3:2]), e ? 32'h0000_0002 : 32'h0000_0001);
            apb(0, `MIC_CTRL_ADDR, 0);
            chk("flag clear", 32'(rd[3:2]), 32'h0000_0003);
        end
        // interrupt: masked, raised, cleared by writing one
        apb(0, `MIC_IRQ_STAT_ADDR, 0);
        chk("irq stat", rd, 32'h0000_0003);
        chk("irq masked", 32'(irq), 0);
        apb(1, `MIC_IRQ_MASK_ADDR, 32'h0000_0001);
        @(posedge clk_sys);
        chk("irq up", 32'(irq), 32'h0000_0001);
        apb(1, `MIC_IRQ_STAT_ADDR, 32'h0000_0001);
        @(posedge clk_sys);
        chk("irq down", 32'(irq), 0);
        apb(0, `MIC_IRQ_STAT_ADDR, 0);
        chk("irq left", rd, 32'h0000_0002);
        apb(0, 12'h0F0, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        end_sim();
    end
endmodule
